//--- src/ntc_nand_stage.v
// One link of the NAND chain
`timescale 1ns/1ps
`default_nettype none

module ntc_nand_stage (
    // Pin level and result of the previous link
    input wire pin_in,
    input wire prev_in,
    // Result passed on toward the chain output
    output wire stage_out
);

    assign stage_out = ~(pin_in & prev_in);

endmodule // ntc_nand_stage

`default_nettype wire

//--- src/ntc_nand_tree_test.v
// Pin-connectivity test mode: strap capture, NAND chain and pin steering
`timescale 1ns/1ps
`default_nettype none
`include "ntc_regs.vh"

module ntc_nand_tree_test (
    // Core clock and synchronous reset
    input wire core_clk,
    input wire reset,
    // Chip reset and bus clock pins, asynchronous to core_clk
    input wire chip_reset_n_pin,
    input wire pci_bus_clock,
    // Chain pin input levels; bit 0 is chain_head_strap
    input wire [`NTC_CHAIN_LEN-1:0] chain_pin_in,
    // Functional drive of the chain pins from the normal logic
    input wire [`NTC_CHAIN_LEN-1:0] func_pin_out,
    input wire [`NTC_CHAIN_LEN-1:0] func_pin_oe,
    // Functional drive of the AD0 line
    input wire func_ad0_out,
    input wire func_ad0_oe,
    // Chain pin drive toward the pads
    output reg [`NTC_CHAIN_LEN-1:0] pin_out_r,
    output reg [`NTC_CHAIN_LEN-1:0] pin_oe_r,
    // AD0 line drive toward the pad
    output reg ad0_out_r,
    output reg ad0_oe_r,
    // Test mode status
    output reg test_mode_r
);

    // Two-stage synchronisers; first stages are read only by second stages
    reg rst_meta_r;
    reg rst_sync_r;
    reg clk_meta_r;
    reg clk_sync_r;
    reg clk_prev_r;
    reg [`NTC_CHAIN_LEN-1:0] pin_meta_r;
    reg [`NTC_CHAIN_LEN-1:0] pin_sync_r;

    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg [1:0] edge_cnt_r;
    reg [1:0] edge_cnt_nxt;

    wire clk_rise;
    wire straps_high;
    wire [`NTC_CHAIN_LEN-1:0] link;
    wire in_test;
    wire [`NTC_CHAIN_LEN-1:0] chain_in;

    reg [`NTC_CHAIN_LEN-1:0] pin_out_nxt;
    reg [`NTC_CHAIN_LEN-1:0] pin_oe_nxt;
    reg ad0_out_nxt;
    reg ad0_oe_nxt;
    reg test_mode_nxt;

    // Chip reset and bus clock synchronisers rest at their idle high level, so a
    // core reset fakes neither a chip reset nor a bus clock rising edge
    always @(posedge core_clk) begin
        if (reset) begin
            rst_meta_r <= 1'h1;
            rst_sync_r <= 1'h1;
        end else begin
            rst_meta_r <= chip_reset_n_pin;
            rst_sync_r <= rst_meta_r;
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            clk_meta_r <= 1'h1;
            clk_sync_r <= 1'h1;
            clk_prev_r <= 1'h1;
        end else begin
            clk_meta_r <= pci_bus_clock;
            clk_sync_r <= clk_meta_r;
            clk_prev_r <= clk_sync_r;
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            pin_meta_r <= {`NTC_CHAIN_LEN{1'h0}};
            pin_sync_r <= {`NTC_CHAIN_LEN{1'h0}};
        end else begin
            pin_meta_r <= chain_pin_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    assign clk_rise = clk_sync_r & ~clk_prev_r;
    assign straps_high = pin_sync_r[0] & pin_sync_r[`NTC_SECOND_STRAP_BIT];
    assign in_test = (state_r == `NTC_ST_TEST);

    // Chain inputs are held low outside test, so pin activity in normal use
    // never toggles the chain and it cannot disturb any pad
    assign chain_in = pin_sync_r & {`NTC_CHAIN_LEN{in_test}};

    // Strap capture sequence
    always @* begin
        state_nxt = state_r;
        edge_cnt_nxt = edge_cnt_r;
        if (clk_rise && edge_cnt_r != `NTC_MIN_CLK_TOGGLES)
            edge_cnt_nxt = edge_cnt_r + 2'h1;
        case (state_r)
            `NTC_ST_NORMAL: begin
                if (!rst_sync_r) begin
                    state_nxt = `NTC_ST_HELD;
                    edge_cnt_nxt = 2'h0;
                end
            end
            `NTC_ST_HELD: begin
                if (rst_sync_r) begin
                    // Straps are judged at the release edge only
                    // A short clock count while held means the capture is unreliable
                    if (straps_high && edge_cnt_r == `NTC_MIN_CLK_TOGGLES) begin
                        state_nxt = `NTC_ST_POST;
                        edge_cnt_nxt = 2'h0;
                    end else begin
                        state_nxt = `NTC_ST_NORMAL;
                    end
                end
            end
            `NTC_ST_POST: begin
                if (!rst_sync_r) begin
                    state_nxt = `NTC_ST_HELD;
                    edge_cnt_nxt = 2'h0;
                end else if (edge_cnt_r == `NTC_MIN_CLK_TOGGLES) begin
                    state_nxt = `NTC_ST_TEST;
                end
            end
            `NTC_ST_TEST: begin
                // Only a new reset leaves test; the tester keeps it high meanwhile
                if (!rst_sync_r) begin
                    state_nxt = `NTC_ST_HELD;
                    edge_cnt_nxt = 2'h0;
                end
            end
            default: begin
                state_nxt = `NTC_ST_NORMAL;
                edge_cnt_nxt = 2'h0;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (reset) begin
            state_r <= `NTC_ST_NORMAL;
        end else begin
            state_r <= state_nxt;
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            edge_cnt_r <= 2'h0;
        end else begin
            edge_cnt_r <= edge_cnt_nxt;
        end
    end

    // Chain from the head strap toward AD0; only chain pins feed it
    // Deeper links invert earlier ones, so each pin lowered in order from the head flips the end
    ntc_nand_stage u_head (
        .pin_in(chain_in[0]),
        .prev_in(1'b1),
        .stage_out(link[0])
    );

    genvar gi;
    generate
        for (gi = 1; gi < `NTC_CHAIN_LEN; gi = gi + 1) begin : g_link
            ntc_nand_stage u_stage (
                .pin_in(chain_in[gi]),
                .prev_in(link[gi-1]),
                .stage_out(link[gi])
            );
        end
    endgenerate

    // Pad steering; the chain output lags the pins by the synchroniser depth plus the output register
    always @* begin
        if (in_test) begin
            // Chain pins are released so the tester can drive them
            pin_out_nxt = {`NTC_CHAIN_LEN{1'h0}};
            pin_oe_nxt = {`NTC_CHAIN_LEN{1'h0}};
            ad0_out_nxt = link[`NTC_CHAIN_LEN-1];
            ad0_oe_nxt = 1'h1;
            test_mode_nxt = 1'h1;
        end else begin
            pin_out_nxt = func_pin_out;
            pin_oe_nxt = func_pin_oe;
            ad0_out_nxt = func_ad0_out;
            ad0_oe_nxt = func_ad0_oe;
            test_mode_nxt = 1'h0;
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            pin_out_r <= {`NTC_CHAIN_LEN{1'h0}};
            pin_oe_r <= {`NTC_CHAIN_LEN{1'h0}};
            ad0_out_r <= 1'h0;
            ad0_oe_r <= 1'h0;
            test_mode_r <= 1'h0;
        end else begin
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
            ad0_out_r <= ad0_out_nxt;
            ad0_oe_r <= ad0_oe_nxt;
            test_mode_r <= test_mode_nxt;
        end
    end

endmodule // ntc_nand_tree_test

`default_nettype wire

//--- src/ntc_regs.vh
// Constants for the pin-connectivity (NAND chain) test block
`ifndef NTC_REGS_VH
`define NTC_REGS_VH

// Pins in the chain, counted from the head strap (index 0) to the last pin
`define NTC_CHAIN_LEN 16
// Chain position of the second test strap
`define NTC_SECOND_STRAP_BIT 2
// Least number of bus clock rising edges on each side of the reset release
`define NTC_MIN_CLK_TOGGLES 2'h2

// One-hot states of the strap capture sequence
`define NTC_ST_NORMAL 4'h1
`define NTC_ST_HELD 4'h2
`define NTC_ST_POST 4'h4
`define NTC_ST_TEST 4'h8

`endif

//--- verif/ntc_nand_tree_test_props.sv
// Assertions on the NAND chain test block ports
`timescale 1ns/1ps
`default_nettype none
module ntc_nand_tree_test_props (
    // Clock, reset and pins
    input wire logic core_clk,
    input wire logic reset,
    input wire logic chip_reset_n_pin,
    input wire logic [15:0] chain_pin_in,
    input wire logic [15:0] func_pin_out,
    input wire logic func_ad0_oe,
    // Pad drive and status
    input wire logic [15:0] pin_out_r,
    input wire logic [15:0] pin_oe_r,
    input wire logic ad0_out_r,
    input wire logic ad0_oe_r,
    input wire logic test_mode_r
);
    logic rst_pin_r, straps_ok_r;
    logic [2:0] quiet_r;
    always @(posedge core_clk) begin
        rst_pin_r <= chip_reset_n_pin;
        if (chip_reset_n_pin && !rst_pin_r) straps_ok_r <= chain_pin_in[0] & chain_pin_in[2];
        quiet_r <= (reset || test_mode_r) ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h7};
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    a_entry_needs_straps: assert property ($rose(test_mode_r) |-> straps_ok_r)
        else $error("test mode without straps");
    a_test_pad_drive: assert property (test_mode_r && $past(test_mode_r) |->
        ad0_oe_r && pin_oe_r == 16'h0) else $error("pad drive wrong in test");
    a_chain_step_latency: assert property ($changed(ad0_out_r) && test_mode_r &&
        $past(test_mode_r) |-> $past(chain_pin_in, 3) != $past(chain_pin_in, 4))
        else $error("chain output moved alone");
    a_clock_outside: assert property (test_mode_r ##1
        ($stable(chain_pin_in) && test_mode_r) [*4] |-> $stable(ad0_out_r))
        else $error("chain output moved with pins still");
    a_normal_follow: assert property (quiet_r == 3'h7 ##1 !test_mode_r |->
        $past(pin_out_r) == $past(func_pin_out, 2) && $past(ad0_oe_r) == $past(func_ad0_oe, 2))
        else $error("normal drive not passed through");
endmodule // ntc_nand_tree_test_props
bind ntc_nand_tree_test ntc_nand_tree_test_props ntc_nand_tree_test_props_inst (
    .core_clk(core_clk), .reset(reset), .chip_reset_n_pin(chip_reset_n_pin),
    .chain_pin_in(chain_pin_in), .func_pin_out(func_pin_out), .func_ad0_oe(func_ad0_oe),
    .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r), .ad0_out_r(ad0_out_r), .ad0_oe_r(ad0_oe_r),
    .test_mode_r(test_mode_r));
`default_nettype wire

//--- verif/ntc_tester_model.sv
// Board tester model driving straps, bus clock and chain pins
`timescale 1ns/1ps
`default_nettype none
module ntc_tester_model (
    // Pacing clock
    input wire logic core_clk,
    // Device pins
    output logic chip_reset_n_pin,
    output logic pci_bus_clock,
    output logic [15:0] chain_pin_in
);
    initial {chip_reset_n_pin, pci_bus_clock, chain_pin_in} = 18'h3ffff;
    task automatic w(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Bus clock rests high, so each pulse gives one rising edge
    task automatic pulse(input int n);
        for (int i = 0; i < 2 * n; i++) begin
            w(4);
            pci_bus_clock = ~pci_bus_clock;
        end
    endtask
    task automatic strap(input logic s0, input logic s2, input int n);
        chain_pin_in = {13'h1fff, s2, 1'b1, s0};
        chip_reset_n_pin = 1'b0;
        pulse(n);
        // The last held edge must be counted before the release is seen
        w(4);
        chip_reset_n_pin = 1'b1;
        pulse(n);
        chain_pin_in = 16'hffff;
        w(8);
    endtask
    task automatic lower(input int k);
        chain_pin_in[k] = 1'b0;
        w(5);
    endtask
endmodule // ntc_tester_model
`default_nettype wire

//--- verif/test_ntc_nand_tree_test.sv
// Self-checking bench for the NAND chain test block
`timescale 1ns/1ps
`default_nettype none
module test_ntc_nand_tree_test;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic rn, pclk, ad0, ad0_oe, tm;
    logic [15:0] pins, po, poe;
    logic [15:0] fo = 16'h5a3c;
    logic [15:0] foe = 16'h0ff0;
    logic fa = 1'b1;
    logic fae = 1'b0;
    int fails = 0;
    int samples_checked = 0;
    always #25 core_clk = ~core_clk;
    ntc_tester_model ntc_tester_model_inst (.core_clk(core_clk), .chip_reset_n_pin(rn),
        .pci_bus_clock(pclk), .chain_pin_in(pins));
    ntc_nand_tree_test ntc_nand_tree_test_inst (.core_clk(core_clk), .reset(reset),
        .chip_reset_n_pin(rn), .pci_bus_clock(pclk), .chain_pin_in(pins), .func_pin_out(fo),
        .func_pin_oe(foe), .func_ad0_out(fa), .func_ad0_oe(fae), .pin_out_r(po),
        .pin_oe_r(poe), .ad0_out_r(ad0), .ad0_oe_r(ad0_oe), .test_mode_r(tm));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Good straps, then each pin lowered in order must flip the output
    task automatic walk_chain;
        logic exp;
        ntc_tester_model_inst.strap(1'b1, 1'b1, 2);
        chk("mode", {15'h0, tm}, 16'h1);
        chk("pin oe test", poe, 16'h0);
        chk("pin out test", po, 16'h0);
        chk("ad0 oe test", {15'h0, ad0_oe}, 16'h1);
        exp = ad0;
        for (int k = 0; k < 16; k++) begin
            ntc_tester_model_inst.lower(k);
            exp = ~exp;
            chk("ad0", {15'h0, ad0}, {15'h0, exp});
        end
        chk("ad0 all low", {15'h0, ad0}, 16'h1);
        ntc_tester_model_inst.pulse(2);
        ntc_tester_model_inst.w(4);
        chk("ad0 clk", {15'h0, ad0}, 16'h1);
    endtask
    // A strap low or too few bus clock pulses keeps normal pin drive
    task automatic refused;
        ntc_tester_model_inst.strap(1'b1, 1'b0, 2);
        chk("mode s2", {15'h0, tm}, 16'h0);
        chk("pins", po, fo);
        chk("pin oe", poe, foe);
        chk("ad0 normal", {14'h0, ad0_oe, ad0}, {14'h0, fae, fa});
        ntc_tester_model_inst.strap(1'b0, 1'b1, 2);
        chk("mode s0", {15'h0, tm}, 16'h0);
        ntc_tester_model_inst.strap(1'b1, 1'b1, 1);
        chk("mode clk", {15'h0, tm}, 16'h0);
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        #1 reset = 1'b0;
        walk_chain();
        refused();
        finish_test();
    end
    initial begin
        #2000000;
        fails++;
        finish_test();
    end
endmodule // test_ntc_nand_tree_test
`default_nettype wire
